// >>> core/regulator_bank.sv
// Behaviour
// - Each alternate setting enable holds one of off, on, or switched on by the power-up sequence.
// - A low-power flag of 0 runs the regulator in normal mode and 1 in power-save mode.
// - The primary setting's source select picks whether the primary or the alternate code is applied.
// - Each setting register holds a six-bit voltage code in bits five to zero that sets the output.
// - The six-bit ceiling bounds the code of both setting registers of the same regulator.
// - A written code above the ceiling is discarded and the previous code kept.
// - A ceiling other than all zeros or all ones makes the ceiling register read-only.
// - Power-on reset restores defaults, with codes and enables taken from one-time-programmed memory.
//
// Purpose: Wishbone slave holding the setting registers of two regulators
// Assumes: otp default inputs are stable, same-clock outputs of the otp controller
// Notes: answers every access one cycle after it is taken; unmapped reads return zero
`timescale 1ns/1ps
module regulator_bank (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire regulator_pkg::otp_defaults_s LDO2_OTP_I,
  input wire regulator_pkg::otp_defaults_s LDO3_OTP_I,
  output regulator_pkg::regulator_status_s LDO2_STATUS_O,
  output regulator_pkg::regulator_status_s LDO3_STATUS_O
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  regulator_pkg::bus_state_e state_reg, state_next;
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  regulator_pkg::regulator_status_s ldo2_status_reg, ldo2_status_next;
  regulator_pkg::regulator_status_s ldo3_status_reg, ldo3_status_next;
  regulator_pkg::regulator_status_s ldo2_status, ldo3_status;
  logic [5:0] index;
  logic request;
  logic write_commit;
  logic load;
  logic [7:0] ldo2_primary, ldo2_alternate, ldo2_ceiling;
  logic [7:0] ldo3_primary, ldo3_alternate, ldo3_ceiling;
  logic [7:0] read_byte;
  logic [7:0] wdata;

  assign index = ADR_I[7:2];
  assign request = CYC_I && STB_I;
  assign load = (state_reg == regulator_pkg::ST_LOAD);
  // a write lands at the edge where the master samples ack
  assign write_commit = (state_reg == regulator_pkg::ST_ACK) && request && WE_I && SEL_I[0];
  // only the low byte lane carries data
  assign wdata = DAT_I[regulator_pkg::BYTE_MSB:0];

  // ----------------------------------------------------------------
  // register units
  // ----------------------------------------------------------------
  regulator_unit u_ldo2 (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .load_i(load),
    .otp_i(LDO2_OTP_I),
    .wr_primary_i(write_commit && index == regulator_pkg::IDX_LDO2_PRIMARY),
    .wr_alternate_i(write_commit && index == regulator_pkg::IDX_LDO2_ALTERNATE),
    .wr_ceiling_i(write_commit && index == regulator_pkg::IDX_LDO2_CEILING),
    .wdata_i(wdata),
    .primary_o(ldo2_primary),
    .alternate_o(ldo2_alternate),
    .ceiling_o(ldo2_ceiling),
    .status_o(ldo2_status)
  );

  regulator_unit u_ldo3 (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .load_i(load),
    .otp_i(LDO3_OTP_I),
    .wr_primary_i(write_commit && index == regulator_pkg::IDX_LDO3_PRIMARY),
    .wr_alternate_i(write_commit && index == regulator_pkg::IDX_LDO3_ALTERNATE),
    .wr_ceiling_i(write_commit && index == regulator_pkg::IDX_LDO3_CEILING),
    .wdata_i(wdata),
    .primary_o(ldo3_primary),
    .alternate_o(ldo3_alternate),
    .ceiling_o(ldo3_ceiling),
    .status_o(ldo3_status)
  );

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  // unmapped indices read as zero
  always_comb begin
    case (index)
      regulator_pkg::IDX_LDO2_PRIMARY: begin
        read_byte = ldo2_primary;
      end
      regulator_pkg::IDX_LDO2_ALTERNATE: begin
        read_byte = ldo2_alternate;
      end
      regulator_pkg::IDX_LDO2_CEILING: begin
        read_byte = ldo2_ceiling;
      end
      regulator_pkg::IDX_LDO3_PRIMARY: begin
        read_byte = ldo3_primary;
      end
      regulator_pkg::IDX_LDO3_ALTERNATE: begin
        read_byte = ldo3_alternate;
      end
      regulator_pkg::IDX_LDO3_CEILING: begin
        read_byte = ldo3_ceiling;
      end
      default: begin
        read_byte = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // load otp once, then answer each request with a single ack
  always_comb begin
    state_next = state_reg;
    ack_next = 1'b0;
    dat_next = dat_reg;
    case (state_reg)
      regulator_pkg::ST_LOAD: begin
        state_next = regulator_pkg::ST_IDLE;
      end
      regulator_pkg::ST_IDLE: begin
        if (request) begin
          state_next = regulator_pkg::ST_ACK;
          ack_next = 1'b1;
          dat_next = {24'h00_0000, read_byte};
        end
      end
      regulator_pkg::ST_ACK: begin
        state_next = regulator_pkg::ST_IDLE;
      end
      default: begin
        state_next = regulator_pkg::ST_IDLE;
      end
    endcase
  end

  // bus state register
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= regulator_pkg::ST_LOAD;
      ack_reg <= 1'b0;
      dat_reg <= regulator_pkg::BUS_DATA_RESET;
    end else begin
      state_reg <= state_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // ----------------------------------------------------------------
  // applied regulator state
  // ----------------------------------------------------------------
  // applied code follows the source select
  always_comb begin
    ldo2_status_next = ldo2_status;
    ldo3_status_next = ldo3_status;
  end

  // status outputs leave from flops
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ldo2_status_reg <= '{mode: regulator_pkg::MODE_OFF, low_power_flag: 1'b0, code: regulator_pkg::CODE_RESET};
      ldo3_status_reg <= '{mode: regulator_pkg::MODE_OFF, low_power_flag: 1'b0, code: regulator_pkg::CODE_RESET};
    end else begin
      ldo2_status_reg <= ldo2_status_next;
      ldo3_status_reg <= ldo3_status_next;
    end
  end

  assign DAT_O = dat_reg;
  assign ACK_O = ack_reg;
  assign LDO2_STATUS_O = ldo2_status_reg;
  assign LDO3_STATUS_O = ldo3_status_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence bus_request_s;
    (state_reg == regulator_pkg::ST_IDLE) && request;
  endsequence

  sequence single_ack_s;
    ACK_O ##1 !ACK_O;
  endsequence

  chk_bus_single_ack: assert property (
    bus_request_s |=> single_ack_s)
    else $error("request not answered by one ack");

  chk_reserved_zero: assert property (
    ACK_O |-> DAT_O[31:8] == 24'h00_0000 && !(index == regulator_pkg::IDX_LDO2_PRIMARY && DAT_O[7]))
    else $error("reserved bits read nonzero");

  chk_source_select: assert property (
    write_commit && index == regulator_pkg::IDX_LDO2_PRIMARY && wdata[regulator_pkg::SOURCE_SELECT_BIT]
    |=> ##1 LDO2_STATUS_O.code == $past(ldo2_alternate[regulator_pkg::CODE_MSB:0]))
    else $error("alternate code not applied when selected");

  chk_code_width: assert property (
    write_commit && index == regulator_pkg::IDX_LDO3_PRIMARY && !wdata[regulator_pkg::SOURCE_SELECT_BIT]
    && (wdata[5:0] <= ldo3_ceiling[5:0]) |=> ##1 LDO3_STATUS_O.code == $past(wdata[5:0], 2))
    else $error("written code not applied");

  chk_ldo2_applied_code: assert property (
    LDO2_STATUS_O.code == $past(ldo2_primary[regulator_pkg::SOURCE_SELECT_BIT] ?
    ldo2_alternate[regulator_pkg::CODE_MSB:0] : ldo2_primary[regulator_pkg::CODE_MSB:0]))
    else $error("ldo2 applied code does not follow source select");

  chk_ldo3_applied_code: assert property (
    LDO3_STATUS_O.code == $past(ldo3_primary[regulator_pkg::SOURCE_SELECT_BIT] ?
    ldo3_alternate[regulator_pkg::CODE_MSB:0] : ldo3_primary[regulator_pkg::CODE_MSB:0]))
    else $error("ldo3 applied code does not follow source select");

  chk_ldo2_power_save: assert property (
    LDO2_STATUS_O.low_power_flag == $past(ldo2_alternate[regulator_pkg::LOW_POWER_BIT]))
    else $error("ldo2 low-power flag not applied");

  chk_ldo3_power_save: assert property (
    LDO3_STATUS_O.low_power_flag == $past(ldo3_alternate[regulator_pkg::LOW_POWER_BIT]))
    else $error("ldo3 low-power flag not applied");

  chk_ldo2_enable_state: assert property (
    LDO2_STATUS_O.mode != 2'b11 &&
    (LDO2_STATUS_O.mode != regulator_pkg::MODE_OFF) == $past(ldo2_alternate[regulator_pkg::ENABLE_BIT]))
    else $error("ldo2 enable state illegal or not applied");

  chk_ldo3_enable_state: assert property (
    LDO3_STATUS_O.mode != 2'b11 &&
    (LDO3_STATUS_O.mode != regulator_pkg::MODE_OFF) == $past(ldo3_alternate[regulator_pkg::ENABLE_BIT]))
    else $error("ldo3 enable state illegal or not applied");

  chk_ldo2_alt_kept: assert property (
    write_commit && index == regulator_pkg::IDX_LDO2_ALTERNATE
    && (wdata[regulator_pkg::CODE_MSB:0] > ldo2_ceiling[regulator_pkg::CODE_MSB:0])
    |=> $stable(ldo2_alternate[regulator_pkg::CODE_MSB:0]))
    else $error("over-ceiling ldo2 alternate code was stored");

  chk_ldo3_primary_kept: assert property (
    write_commit && index == regulator_pkg::IDX_LDO3_PRIMARY
    && (wdata[regulator_pkg::CODE_MSB:0] > ldo3_ceiling[regulator_pkg::CODE_MSB:0])
    |=> $stable(ldo3_primary[regulator_pkg::CODE_MSB:0]))
    else $error("over-ceiling ldo3 primary code was stored");

  chk_ldo3_ceiling_lock: assert property (
    write_commit && index == regulator_pkg::IDX_LDO3_CEILING
    && regulator_pkg::ceiling_locked(ldo3_ceiling[regulator_pkg::CODE_MSB:0]) |=> $stable(ldo3_ceiling))
    else $error("locked ldo3 ceiling was changed");

  chk_ldo2_ceiling_open: assert property (
    write_commit && index == regulator_pkg::IDX_LDO2_CEILING
    && !regulator_pkg::ceiling_locked(ldo2_ceiling[regulator_pkg::CODE_MSB:0])
    |=> ldo2_ceiling == {2'b00, $past(wdata[regulator_pkg::CODE_MSB:0])})
    else $error("open ldo2 ceiling did not take the write");

  chk_unmapped_zero: assert property (
    bus_request_s ##0 (index < regulator_pkg::IDX_LDO2_PRIMARY || index > regulator_pkg::IDX_LDO3_CEILING)
    |=> DAT_O == 32'h0000_0000)
    else $error("unmapped index returned nonzero data");

  chk_otp_enable: assert property (
    load |=> ##1 LDO3_STATUS_O.mode == $past(LDO3_OTP_I.enable, 2)
    && LDO2_STATUS_O.mode == $past(LDO2_OTP_I.enable, 2))
    else $error("otp enable not applied after reset");

  // low lane masked write leaves every setting alone
  chk_masked_lane: assert property (
    ACK_O && request && WE_I && !SEL_I[0]
    |=> $stable(ldo2_primary) && $stable(ldo2_alternate) && $stable(ldo3_primary) && $stable(ldo3_alternate))
    else $error("write with low lane masked changed a register");

endmodule // regulator_bank

// >>> inc/regulator_pkg.sv
// Purpose: shared constants, types and helpers for the regulator setting registers
// Assumes: 32-bit classic Wishbone slave, one register per aligned word
// Notes: register indices are word indices; byte address is four times the index
package regulator_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_LDO2_PRIMARY = 6'h13;
  localparam logic [5:0] IDX_LDO2_ALTERNATE = 6'h14;
  localparam logic [5:0] IDX_LDO2_CEILING = 6'h15;
  localparam logic [5:0] IDX_LDO3_PRIMARY = 6'h16;
  localparam logic [5:0] IDX_LDO3_ALTERNATE = 6'h17;
  localparam logic [5:0] IDX_LDO3_CEILING = 6'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT = 7;
  localparam int LOW_POWER_BIT = 6;
  localparam int SOURCE_SELECT_BIT = 6;
  localparam int CODE_MSB = 5;
  localparam int BYTE_MSB = 7;

  // ----------------------------------------------------------------
  // special and reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] CEILING_OPEN_LOW = 6'h00;
  localparam logic [5:0] CEILING_OPEN_HIGH = 6'h3f;
  localparam logic [5:0] CODE_RESET = 6'h00;
  localparam logic [5:0] CEILING_RESET = 6'h00;
  localparam logic [31:0] BUS_DATA_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_ON = 2'b01,
    MODE_SEQUENCED = 2'b10
  } enable_mode_e;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } bus_state_e;

  // one-time-programmed defaults of one regulator
  typedef struct packed {
    enable_mode_e enable;
    logic [5:0] primary_code;
    logic [5:0] alternate_code;
    logic [5:0] ceiling_code;
  } otp_defaults_s;

  // applied state of one regulator
  typedef struct packed {
    enable_mode_e mode;
    logic low_power_flag;
    logic [5:0] code;
  } regulator_status_s;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // a code is accepted only when it does not exceed the ceiling
  function automatic logic code_allowed(input logic [5:0] code, input logic [5:0] ceiling);
    code_allowed = (code <= ceiling);
  endfunction

  // the ceiling locks once it holds anything but all zeros or all ones
  function automatic logic ceiling_locked(input logic [5:0] ceiling);
    ceiling_locked = (ceiling != CEILING_OPEN_LOW) && (ceiling != CEILING_OPEN_HIGH);
  endfunction

endpackage

// >>> core/regulator_unit.sv
// Purpose: primary, alternate and ceiling registers of one regulator
// Assumes: write strobes are one-cycle pulses from the bus slave
// Notes: load_i copies the one-time-programmed defaults in once after reset
`timescale 1ns/1ps
module regulator_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire regulator_pkg::otp_defaults_s otp_i,
  input wire logic wr_primary_i,
  input wire logic wr_alternate_i,
  input wire logic wr_ceiling_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] primary_o,
  output logic [7:0] alternate_o,
  output logic [7:0] ceiling_o,
  output regulator_pkg::regulator_status_s status_o
);

  logic source_select_reg, source_select_next;
  logic [5:0] primary_code_reg, primary_code_next;
  regulator_pkg::enable_mode_e mode_reg, mode_next;
  logic low_power_reg, low_power_next;
  logic [5:0] alternate_code_reg, alternate_code_next;
  logic [5:0] ceiling_reg, ceiling_next;
  logic [5:0] wcode;

  assign wcode = wdata_i[regulator_pkg::CODE_MSB:0];

  // ----------------------------------------------------------------
  // next register values
  // ----------------------------------------------------------------
  always_comb begin
    source_select_next = source_select_reg;
    primary_code_next = primary_code_reg;
    mode_next = mode_reg;
    low_power_next = low_power_reg;
    alternate_code_next = alternate_code_reg;
    ceiling_next = ceiling_reg;
    if (load_i) begin
      mode_next = otp_i.enable;
      primary_code_next = otp_i.primary_code;
      alternate_code_next = otp_i.alternate_code;
      ceiling_next = otp_i.ceiling_code;
    end else begin
      if (wr_primary_i) begin
        source_select_next = wdata_i[regulator_pkg::SOURCE_SELECT_BIT];
        if (regulator_pkg::code_allowed(wcode, ceiling_reg)) begin
          primary_code_next = wcode;
        end
      end
      if (wr_alternate_i) begin
        mode_next = wdata_i[regulator_pkg::ENABLE_BIT] ? regulator_pkg::MODE_ON : regulator_pkg::MODE_OFF;
        low_power_next = wdata_i[regulator_pkg::LOW_POWER_BIT];
        if (regulator_pkg::code_allowed(wcode, ceiling_reg)) begin
          alternate_code_next = wcode;
        end
      end
      if (wr_ceiling_i && !regulator_pkg::ceiling_locked(ceiling_reg)) begin
        ceiling_next = wcode;
      end
    end
  end

  // register stage, constant values under reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      source_select_reg <= 1'b0;
      primary_code_reg <= regulator_pkg::CODE_RESET;
      mode_reg <= regulator_pkg::MODE_OFF;
      low_power_reg <= 1'b0;
      alternate_code_reg <= regulator_pkg::CODE_RESET;
      ceiling_reg <= regulator_pkg::CEILING_RESET;
    end else begin
      source_select_reg <= source_select_next;
      primary_code_reg <= primary_code_next;
      mode_reg <= mode_next;
      low_power_reg <= low_power_next;
      alternate_code_reg <= alternate_code_next;
      ceiling_reg <= ceiling_next;
    end
  end

  // ----------------------------------------------------------------
  // read views and applied state
  // ----------------------------------------------------------------
  // reserved bits read zero
  assign primary_o = {1'b0, source_select_reg, primary_code_reg};
  assign alternate_o = {mode_reg != regulator_pkg::MODE_OFF, low_power_reg, alternate_code_reg};
  assign ceiling_o = {2'b00, ceiling_reg};
  assign status_o.code = source_select_reg ? alternate_code_reg : primary_code_reg;
  assign status_o.mode = mode_reg;
  assign status_o.low_power_flag = low_power_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ceiling_lock: assert property (
    wr_ceiling_i && !load_i && regulator_pkg::ceiling_locked(ceiling_reg) |=> $stable(ceiling_reg))
    else $error("locked ceiling was changed");

  chk_over_ceiling: assert property (
    wr_primary_i && !load_i && (wcode > ceiling_reg) |=> $stable(primary_code_reg))
    else $error("over-ceiling primary code was stored");

  chk_alternate_bound: assert property (
    wr_alternate_i && !load_i && (wcode <= ceiling_reg) |=> alternate_code_reg == $past(wcode))
    else $error("allowed alternate code was not stored");

  chk_low_power_mode: assert property (
    wr_alternate_i && !load_i |=> status_o.low_power_flag == $past(wdata_i[regulator_pkg::LOW_POWER_BIT]))
    else $error("low-power flag does not follow write");

  chk_enable_states: assert property (
    load_i |=> status_o.mode == $past(otp_i.enable) ##1 (status_o.mode != 2'b11))
    else $error("enable state not loaded or illegal");

  chk_otp_load: assert property (
    load_i |=> ceiling_reg == $past(otp_i.ceiling_code) && primary_code_reg == $past(otp_i.primary_code))
    else $error("otp defaults not loaded");

endmodule // regulator_unit

// >>> dv/tb_regulator_bank.sv
// Purpose: self-checking bench for the regulator setting register bank
// Assumes: classic Wishbone single cycles, one access per three clocks at best
// Notes: an integer model of both regulators predicts every read and status
`timescale 1ns/1ps
module tb_regulator_bank;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic clk, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  regulator_pkg::otp_defaults_s otp2, otp3;
  regulator_pkg::regulator_status_s st2, st3;
  int n_mismatch = 0, check_count = 0, cycles = 0, seed = 67656;
  int m_pcode[2], m_src[2], m_acode[2], m_lp[2], m_mode[2], m_ceil[2];
  logic [15:0] dir_tab [13] = '{16'h1500, 16'h14c5, 16'h1400, 16'h153f, 16'h13ff, 16'h149e, 16'h1510,
                                16'h153f, 16'h1311, 16'h1350, 16'h183f, 16'h17ff, 16'h166a};

  regulator_bank dut (.CLK_I(clk), .RST_I(rst_i), .CYC_I(cyc_i), .STB_I(stb_i), .WE_I(we_i),
    .ADR_I(adr_i), .SEL_I(sel_i), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack_o),
    .LDO2_OTP_I(otp2), .LDO3_OTP_I(otp3), .LDO2_STATUS_O(st2), .LDO3_STATUS_O(st3));

  // 25 MHz clock
  always #20 clk = ~clk;

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // bus master: hold until ack, release, one idle cycle
  // ----------------------------------------------------------------
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     input logic [3:0] sel, output logic [31:0] data);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    adr_i <= adr;
    dat_i <= dat;
    sel_i <= sel;
    do begin
      @(posedge clk);
    end while (ack_o !== 1'b1);
    data = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  // otp defaults load
  task automatic mdl_reset();
    m_pcode = '{int'(otp2.primary_code), int'(otp3.primary_code)};
    m_acode = '{int'(otp2.alternate_code), int'(otp3.alternate_code)};
    m_ceil = '{int'(otp2.ceiling_code), int'(otp3.ceiling_code)};
    m_mode = '{int'(otp2.enable), int'(otp3.enable)};
    m_src = '{0, 0};
    m_lp = '{0, 0};
  endtask

  task automatic mdl_write(input int idx, input logic [31:0] d, input logic [3:0] sel);
    int r, f, c;
    r = (idx >= 'h16) ? 1 : 0;
    f = (idx - 'h13) % 3;
    c = int'(d[5:0]);
    if (!sel[0] || idx < 'h13 || idx > 'h18) return;
    if (f == 0) begin
      m_src[r] = d[6];
      if (c <= m_ceil[r]) m_pcode[r] = c;
    end else if (f == 1) begin
      m_mode[r] = d[7];
      m_lp[r] = d[6];
      if (c <= m_ceil[r]) m_acode[r] = c;
    end else if (m_ceil[r] == 0 || m_ceil[r] == 63) begin
      m_ceil[r] = c;
    end
  endtask

  function automatic logic [31:0] mdl_read(input int idx);
    int r, f;
    r = (idx >= 'h16) ? 1 : 0;
    f = (idx - 'h13) % 3;
    if (idx < 'h13 || idx > 'h18) return 32'h0000_0000;
    if (f == 0) return 32'(m_src[r] * 64 + m_pcode[r]);
    if (f == 1) return 32'((m_mode[r] != 0) * 128 + m_lp[r] * 64 + m_acode[r]);
    return 32'(m_ceil[r]);
  endfunction

  function automatic logic [31:0] mdl_status(input int r);
    return 32'(m_mode[r] * 128 + m_lp[r] * 64 + (m_src[r] ? m_acode[r] : m_pcode[r]));
  endfunction

  // read one index, ignored low address bits randomised, then both status ports
  task automatic rd_chk(input int idx);
    bus(1'b0, {6'(idx), 2'($random(seed))}, 32'($random(seed)), 4'hf, rd);
    check(rd, mdl_read(idx));
    check(32'(st2), mdl_status(0));
    check(32'(st3), mdl_status(1));
  endtask

  // writable bits of each register; reserved places are written as zero
  function automatic logic [7:0] keep_mask(input int idx);
    if (idx == 'h13 || idx == 'h16) return 8'h7f;
    if (idx == 'h15 || idx == 'h18) return 8'h3f;
    return 8'hff;
  endfunction

  task automatic wr_chk(input int idx, input logic [31:0] d, input logic [3:0] sel);
    d[7:0] = d[7:0] & keep_mask(idx);
    bus(1'b1, {6'(idx), 2'b00}, d, sel, rd);
    mdl_write(idx, d, sel);
    rd_chk(idx);
  endtask

  task automatic defaults_chk();
    for (int i = 'h12; i <= 'h19; i++) rd_chk(i);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i} = 3'b000;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0000_0000;
    otp2 = '{regulator_pkg::MODE_SEQUENCED, 6'h12, 6'h05, 6'h3f};
    otp3 = '{regulator_pkg::MODE_ON, 6'h20, 6'h10, 6'h2a};
    repeat (8) @(posedge clk);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk);
    mdl_reset();
    defaults_chk();
    $display("test defaults done");
    foreach (dir_tab[i]) wr_chk(dir_tab[i][15:8], {24'h0, dir_tab[i][7:0]}, 4'hf);
    wr_chk('h16, 32'h0000_0000, 4'he);
    $display("test directed done");
    // random writes, masked lanes and unmapped places included
    repeat (80) wr_chk('h12 + ($random(seed) & 7), 32'($random(seed)), 4'($random(seed)));
    $display("test random done");
    @(posedge clk);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk);
    mdl_reset();
    defaults_chk();
    $display("test reset done");
    give_verdict();
  end
endmodule // tb_regulator_bank
